// ===== hdl/sio_defines.svh
// Offsets, field positions, reset values and timing counts of the synchronous serial port.
`ifndef SIO_DEFINES_SVH
`define SIO_DEFINES_SVH
`define ADDR_CONTROL 8'h20
`define ADDR_STATUS 8'h21
`define ADDR_DATA 8'h22
`define CTL_STOP_BIT 6
`define CONTROL_RESET 8'h00
`define RX_BUFFER_RESET 8'h00
`define TX_BUFFER_RESET 8'h00
`define ST_TX_UNDERRUN_FLAG_BIT 3
`define ST_RX_OVERRUN_FLAG_BIT 2
`define CLK_SEL_EXTERNAL 3'h7
`define CLK_SEL_SLOWEST 3'h0
`define FC_HALF_SLOWEST 12'h7FF
`define FC_SHIFT_BASE 4'h8
`define FS_HALF_TICKS_DEFAULT 8
`define LAST_BIT_INDEX 3'h7
`define IDLE_LINE_LEVEL 1'b1
`endif

// ===== hdl/sio_pkg.sv
// Types shared by the synchronous serial port files.
package sio_pkg;
  // Transfer mode codes, in register order.
  typedef enum logic [1:0] {MODE_TX, MODE_RX, MODE_TXRX, MODE_RSVD} xfer_mode_t;
  // Control register layout, top bit first.
  typedef struct packed {
    logic transfer_start_bit;
    logic force_stop_bit;
    xfer_mode_t transfer_mode_field;
    logic bit_order_select;
    logic [2:0] clock_select;
  } control_t;
  // Status register layout, top bit first.
  typedef struct packed {
    logic transfer_active_flag;
    logic clock_count_flag;
    logic tx_buffer_empty_flag;
    logic rx_buffer_full_flag;
    logic tx_underrun_flag;
    logic rx_overrun_flag;
    logic [1:0] unused;
  } status_t;
  // Transfer engine states.
  typedef enum logic [1:0] {ENG_IDLE, ENG_SHIFT, ENG_GAP} engine_state_t;
endpackage : sio_pkg

// ===== hdl/pin_edge_detect.sv
// Edge detector for a pin that is already synchronous to the clock.
`timescale 1ns/100ps
module pin_edge_detect #(
  parameter logic IDLE_LEVEL = 1'b1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Pin level and its edges.
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic prev_q;

  // The previous level starts at the idle level so that reset makes no false edge.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prev_q <= IDLE_LEVEL;
    else
      prev_q <= level;
  end

  // Edges are seen in the cycle in which the new level arrives.
  assign rise = level && !prev_q;
  assign fall = !level && prev_q;
endmodule : pin_edge_detect

// ===== hdl/sck_rate_gen.sv
// Serial clock rate generator: one enable pulse per half period of the selected rate.
`timescale 1ns/100ps
`include "sio_defines.svh"
module sck_rate_gen #(
  parameter int unsigned FS_HALF_TICKS = `FS_HALF_TICKS_DEFAULT
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Rate selection.
  input wire logic run,
  input wire logic [2:0] clock_select,
  input wire logic use_low_freq,
  input wire logic fs_tick,
  // Half period enable.
  output logic half_tick
);
  logic [11:0] count_q;
  logic [11:0] limit;
  logic step;
  logic low_src;

  // The counter is twelve bits wide, so a longer half period cannot be served.
  if (FS_HALF_TICKS < 1 || FS_HALF_TICKS > 4096)
  begin : g_bad_fs
    $error("FS_HALF_TICKS out of range");
  end

  // Code 000 runs from the low-frequency tick when asked; other codes halve fc step by step.
  always_comb
  begin
    low_src = (clock_select == `CLK_SEL_SLOWEST) && use_low_freq;
    step = low_src ? fs_tick : 1'b1;
    if (low_src)
      limit = 12'(FS_HALF_TICKS - 1);
    else if (clock_select == `CLK_SEL_SLOWEST)
      limit = `FC_HALF_SLOWEST;
    else
      limit = (12'h001 << (`FC_SHIFT_BASE - {1'b0, clock_select})) - 12'h001;
  end

  // Restarting from zero when idle gives a full half period before the first edge.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count_q <= 12'h000;
    else if (!run)
      count_q <= 12'h000;
    else if (step)
      count_q <= (count_q == limit) ? 12'h000 : count_q + 12'h001;
  end

  assign half_tick = run && step && (count_q == limit);
endmodule : sck_rate_gen

// ===== hdl/sync_serial_port_control.sv
// Synchronous serial port: register file, byte transfer engine and pin drivers.
`timescale 1ns/100ps
`include "sio_defines.svh"
// Function
// R01: Control top bit starts or stops transfers.
// R02: Force-stop aborts at once, then self-clears.
// R03: Force-stop resets start, status and buffers.
// R04: Mode field: transmit, receive, full duplex.
// R05: Order bit picks MSB or LSB first.
// R06: Clock field picks divider or external clock.
// R07: Software changes setup only when idle.
// R08: Active flag high while a transfer runs.
// R09: Count flag high between clocks one and seven; here it stays high from the first falling edge to the eighth rising edge.
// R10: Transmit-empty flag shows transmit buffer state.
// R11: Receive-full flag shows waiting received data.
// R12: External clock underrun sets sticky error.
// R13: External clock overrun sets sticky error.
// R14: Stopping transfers leaves error flags alone.
// R15: Writes to a full transmit buffer dropped.
// R16: One address: read receive, write transmit.
// R17: Software avoids read-modify-write on transmit buffer.
// R18: Software sets port latches high first.
// R19: Active flag rises on first falling edge.
// R20: Drive on leading edge, sample on trailing.
// R21: Internal clock pin idles high.
// R22: Internal clock waits for software buffer service.
// R23: Eighth bit loads receive buffer, sets full.
// R24: Transmit write clears empty, shift load sets.
module sync_serial_port_control #(
  parameter int unsigned FS_HALF_TICKS = `FS_HALF_TICKS_DEFAULT
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Clock source options from the system.
  input wire logic timebase_divider_select,
  input wire logic slow_mode,
  input wire logic fs_tick,
  // Serial pins.
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  // Status view for the system.
  output sio_pkg::status_t status
);
  import sio_pkg::*;

  control_t ctrl_q;
  engine_state_t state_q;
  logic [7:0] rx_buf_q, tx_buf_q, shift_q, shift_src, shift_in, rdata_q;
  logic [2:0] bit_cnt_q;
  logic tx_empty_q, rx_full_q, tx_underrun_flag_q, rx_overrun_flag_q, sck_q, so_q;
  logic wr_ctl, wr_st, wr_data, rd_data, force_stop;
  logic ext, has_tx, has_rx, ready, half_tick, pin_rise, pin_fall;
  logic fall_ev, rise_ev, byte_start, byte_done, load_shift, msb_now, lsb_now;

  // Address decode; the data address splits by direction.
  assign wr_ctl = reg_wr && (reg_addr == `ADDR_CONTROL);
  assign wr_st = reg_wr && (reg_addr == `ADDR_STATUS);
  assign wr_data = reg_wr && (reg_addr == `ADDR_DATA); // R16
  assign rd_data = reg_rd && (reg_addr == `ADDR_DATA); // R16
  assign force_stop = wr_ctl && reg_wdata[`CTL_STOP_BIT]; // R02

  // Mode decode; the reserved mode is never ready, so it never starts a byte on the internal clock.
  assign ext = (ctrl_q.clock_select == `CLK_SEL_EXTERNAL); // R06
  assign has_tx = (ctrl_q.transfer_mode_field == MODE_TX) || (ctrl_q.transfer_mode_field == MODE_TXRX); // R04
  assign has_rx = (ctrl_q.transfer_mode_field == MODE_RX) || (ctrl_q.transfer_mode_field == MODE_TXRX); // R04
  assign ready = (ctrl_q.transfer_mode_field != MODE_RSVD) && (!has_tx || !tx_empty_q)
    && (!has_rx || !rx_full_q); // R22

  // Internal serial clock rate; it keeps running to the end of a byte after the start bit drops.
  sck_rate_gen #(
    .FS_HALF_TICKS(FS_HALF_TICKS)
  ) sck_rate_gen_i (
    .clk(clk),
    .rst(rst),
    .run((ctrl_q.transfer_start_bit || (state_q == ENG_SHIFT)) && !ext), // R01
    .clock_select(ctrl_q.clock_select),
    .use_low_freq(timebase_divider_select || slow_mode),
    .fs_tick(fs_tick),
    .half_tick(half_tick)
  );

  // Edges of the clock pin when another party drives it.
  pin_edge_detect #(
    .IDLE_LEVEL(`IDLE_LINE_LEVEL)
  ) pin_edge_detect_i (
    .clk(clk),
    .rst(rst),
    .level(serial_clock_pin_in),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Shift events. With the internal clock a new byte waits at a high clock until the buffers are
  // serviced; with an external clock there is no way to hold the partner, so errors are flagged instead.
  always_comb
  begin
    if (ext)
    begin
      fall_ev = pin_fall && ((state_q == ENG_SHIFT) || ctrl_q.transfer_start_bit);
      rise_ev = pin_rise && (state_q == ENG_SHIFT);
    end
    else
    begin
      fall_ev = half_tick && sck_q && ((state_q == ENG_SHIFT) || (ctrl_q.transfer_start_bit && ready)); // R22
      rise_ev = half_tick && !sck_q;
    end
  end

  // Byte boundaries and the shift register inputs.
  assign byte_start = fall_ev && (state_q != ENG_SHIFT);
  assign byte_done = rise_ev && (bit_cnt_q == `LAST_BIT_INDEX);
  assign load_shift = byte_start && has_tx && !tx_empty_q;
  assign shift_src = load_shift ? tx_buf_q : shift_q;
  assign shift_in = ctrl_q.bit_order_select ? {serial_in_pin, shift_q[7:1]} : {shift_q[6:0], serial_in_pin}; // R05
  assign msb_now = shift_q[7];
  assign lsb_now = shift_q[0];

  // Control register; the force-stop bit reads back as one for a single cycle, then drops.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ctrl_q <= control_t'(`CONTROL_RESET);
    else if (wr_ctl)
    begin
      ctrl_q <= control_t'(reg_wdata); // R01
      if (force_stop)
        ctrl_q.transfer_start_bit <= 1'b0; // R03
    end
    else
      ctrl_q.force_stop_bit <= 1'b0; // R02
  end

  // Transfer engine: the clock pin falls to drive a bit and rises to sample one.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ENG_IDLE;
      bit_cnt_q <= 3'h0;
      sck_q <= `IDLE_LINE_LEVEL;
      so_q <= `IDLE_LINE_LEVEL;
      shift_q <= 8'h00;
    end
    else if (force_stop)
    begin
      state_q <= ENG_IDLE; // R02
      bit_cnt_q <= 3'h0;
      sck_q <= `IDLE_LINE_LEVEL;
      so_q <= `IDLE_LINE_LEVEL;
    end
    else
    begin
      if (ext)
        sck_q <= `IDLE_LINE_LEVEL;
      else if (fall_ev)
        sck_q <= 1'b0;
      else if (rise_ev)
        sck_q <= 1'b1; // R21
      if (fall_ev)
      begin
        shift_q <= shift_src;
        if (has_tx)
          so_q <= ctrl_q.bit_order_select ? shift_src[0] : shift_src[7]; // R20
        else
          so_q <= `IDLE_LINE_LEVEL;
      end
      else if (rise_ev)
      begin
        shift_q <= shift_in; // R20
        bit_cnt_q <= bit_cnt_q + 3'h1;
      end
      case (state_q)
        ENG_IDLE:
        begin
          if (byte_start)
            state_q <= ENG_SHIFT; // R19
        end
        ENG_SHIFT:
        begin
          if (byte_done)
            state_q <= ctrl_q.transfer_start_bit ? ENG_GAP : ENG_IDLE; // R08
        end
        ENG_GAP:
        begin
          if (byte_start)
            state_q <= ENG_SHIFT;
          else if (!ctrl_q.transfer_start_bit)
            state_q <= ENG_IDLE; // R01
        end
        default:
          state_q <= ENG_IDLE;
      endcase
    end
  end

  // Transmit buffer: accepted only when empty; moving it into the shift register empties it.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_buf_q <= `TX_BUFFER_RESET;
      tx_empty_q <= 1'b1;
    end
    else if (force_stop)
    begin
      tx_buf_q <= `TX_BUFFER_RESET; // R03
      tx_empty_q <= 1'b1;
    end
    else if (load_shift)
      tx_empty_q <= 1'b1; // R24
    else if (wr_data && tx_empty_q)
    begin
      tx_buf_q <= reg_wdata; // R15
      tx_empty_q <= 1'b0; // R24
    end
  end

  // Receive buffer: a finished byte loads only into an empty buffer; one that ends while it is full is lost, even with a read in the same cycle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rx_buf_q <= `RX_BUFFER_RESET;
      rx_full_q <= 1'b0;
    end
    else if (force_stop)
    begin
      rx_buf_q <= `RX_BUFFER_RESET; // R03
      rx_full_q <= 1'b0;
    end
    else if (byte_done && has_rx && !rx_full_q)
    begin
      rx_buf_q <= shift_in; // R23
      rx_full_q <= 1'b1; // R11
    end
    else if (rd_data)
      rx_full_q <= 1'b0; // R11
  end

  // Error flags are sticky: a new error wins over a clearing write, and the start bit never clears them.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tx_underrun_flag_q <= 1'b0;
      rx_overrun_flag_q <= 1'b0;
    end
    else if (force_stop)
    begin
      tx_underrun_flag_q <= 1'b0; // R03
      rx_overrun_flag_q <= 1'b0;
    end
    else
    begin
      if (ext && byte_start && has_tx && tx_empty_q)
        tx_underrun_flag_q <= 1'b1; // R12
      else if (wr_st && !reg_wdata[`ST_TX_UNDERRUN_FLAG_BIT])
        tx_underrun_flag_q <= 1'b0; // R12
      if (ext && byte_done && has_rx && rx_full_q)
        rx_overrun_flag_q <= 1'b1; // R13
      else if (wr_st && !reg_wdata[`ST_RX_OVERRUN_FLAG_BIT])
        rx_overrun_flag_q <= 1'b0; // R13
    end
  end

  // Status word, built from live state.
  always_comb
  begin
    status.transfer_active_flag = (state_q != ENG_IDLE); // R08
    status.clock_count_flag = (state_q == ENG_SHIFT); // R09
    status.tx_buffer_empty_flag = tx_empty_q; // R10
    status.rx_buffer_full_flag = rx_full_q; // R11
    status.tx_underrun_flag = tx_underrun_flag_q;
    status.rx_overrun_flag = rx_overrun_flag_q;
    status.unused = 2'h0;
  end

  // Read data: the transmit buffer cannot be read back, so the shared address returns received data.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ADDR_CONTROL: rdata_q <= ctrl_q;
        `ADDR_STATUS: rdata_q <= status;
        `ADDR_DATA: rdata_q <= rx_buf_q; // R16
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // Pin and bus outputs.
  assign reg_rdata = rdata_q;
  assign serial_out_pin = so_q;
  assign serial_clock_pin_out = sck_q;
  assign serial_clock_pin_oe = !ext; // R21

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_stop_clears: assert property ( // R03
    force_stop |=> (state_q == ENG_IDLE) && tx_empty_q && !rx_full_q && !tx_underrun_flag_q && !rx_overrun_flag_q
      && !ctrl_q.transfer_start_bit && ctrl_q.force_stop_bit && (rx_buf_q == 8'h00))
    else $error("force-stop left state behind");
  chk_stop_selfclear: assert property ( // R02
    ctrl_q.force_stop_bit && !wr_ctl |=> !ctrl_q.force_stop_bit)
    else $error("force-stop bit did not clear");
  chk_tx_discard: assert property ( // R15
    wr_data && !tx_empty_q && !force_stop |=> tx_buf_q == $past(tx_buf_q))
    else $error("write to full transmit buffer was taken");
  chk_tx_accept: assert property ( // R24
    wr_data && tx_empty_q && !force_stop |=> !tx_empty_q && (tx_buf_q == $past(reg_wdata)))
    else $error("transmit write not accepted");
  chk_rx_capture: assert property ( // R23
    byte_done && has_rx && !rx_full_q && !force_stop |=> rx_full_q && (rx_buf_q == $past(shift_in)))
    else $error("received byte not loaded");
  chk_overrun_set: assert property ( // R13
    ext && byte_done && has_rx && rx_full_q && !force_stop |=> rx_overrun_flag_q)
    else $error("overrun not flagged");
  chk_error_sticky: assert property ( // R14
    tx_underrun_flag_q && !force_stop && !(wr_st && !reg_wdata[`ST_TX_UNDERRUN_FLAG_BIT]) |=> tx_underrun_flag_q)
    else $error("underrun flag dropped");
  chk_sck_idle_high: assert property ( // R21
    !ext && (state_q != ENG_SHIFT) |-> sck_q)
    else $error("clock pin low outside a byte");
  chk_wait_stall: assert property ( // R22
    !ext && (state_q == ENG_GAP) && !ready && !force_stop |=> sck_q && (state_q != ENG_SHIFT))
    else $error("clock ran without buffer service");
  chk_first_fall: assert property ( // R19
    byte_start && !force_stop |=> status.transfer_active_flag && status.clock_count_flag && (!serial_clock_pin_oe || !sck_q))
    else $error("active flag not raised on first fall");
  chk_count_done: assert property ( // R09
    byte_done && !force_stop |=> !status.clock_count_flag)
    else $error("count flag high after eighth clock");
  chk_msb_first: assert property ( // R05
    fall_ev && (state_q == ENG_SHIFT) && has_tx && !ctrl_q.bit_order_select && !force_stop
      |=> so_q == $past(msb_now))
    else $error("msb-first bit wrong");
  chk_lsb_first: assert property ( // R05
    fall_ev && (state_q == ENG_SHIFT) && has_tx && ctrl_q.bit_order_select && !force_stop
      |=> so_q == $past(lsb_now))
    else $error("lsb-first bit wrong");
endmodule : sync_serial_port_control

// ===== tb/sio_partner.sv
// Behavioural model of the external serial device on the far side of the port.
`timescale 1ns/100ps
module sio_partner (
  // Clock and housekeeping.
  input wire logic clk,
  input wire logic clear,
  // Byte setup.
  input wire logic lsb_first,
  input wire logic [7:0] tx_byte,
  // Serial lines.
  input wire logic sck,
  input wire logic so,
  output logic si,
  // Received byte and frame count.
  output logic [7:0] rx_byte,
  output logic [7:0] frames
);
  logic sck_q;
  logic [2:0] n;
  logic [2:0] idx;
  logic [7:0] shift;
  logic [7:0] nxt;
  // Bit position follows the order chosen for both directions.
  assign idx = lsb_first ? n : 3'h7 - n;
  always_comb
  begin
    nxt = shift;
    nxt[idx] = so;
  end
  // Drive after the falling edge, take on the rising edge; a finished frame inverts the data line.
  always_ff @(posedge clk)
  begin
    sck_q <= sck;
    if (clear)
    begin
      n <= 3'h0;
      frames <= 8'h00;
      si <= 1'b1;
    end
    else if (sck_q && !sck)
      si <= tx_byte[idx];
    else if (!sck_q && sck)
    begin
      shift <= nxt;
      n <= n + 3'h1;
      if (n == 3'h7)
      begin
        rx_byte <= nxt;
        frames <= frames + 8'h01;
        si <= ~si;  // The hold time is over, so the old level must not linger.
      end
    end
  end
endmodule : sio_partner

// ===== tb/sync_serial_port_control_bench.sv
// Self-checking bench for the synchronous serial port.
`timescale 1ns/100ps
module sync_serial_port_control_bench;
  import sio_pkg::*;
  localparam int FS_HALF = 2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic tb_sel = 1'b0;
  logic slow = 1'b0;
  logic fs_tick = 1'b0;
  logic [1:0] fs_cnt = 2'h0;
  logic ext_sck = 1'b1;
  logic p_clr = 1'b1;
  logic p_lsb = 1'b0;
  logic [7:0] p_tx = 8'h00;
  logic [7:0] p_rx;
  logic [7:0] p_frames;
  logic si, so, sck_out, sck_oe;
  status_t status;
  wire sck = sck_oe ? sck_out : ext_sck;
  int fails = 0;
  int n_compared = 0;

  sync_serial_port_control #(.FS_HALF_TICKS(FS_HALF)) sync_serial_port_control_i (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timebase_divider_select(tb_sel), .slow_mode(slow),
    .fs_tick(fs_tick), .serial_in_pin(si), .serial_out_pin(so), .serial_clock_pin_in(sck),
    .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe), .status(status));
  sio_partner sio_partner_i (.clk(clk), .clear(p_clr), .lsb_first(p_lsb), .tx_byte(p_tx), .sck(sck),
    .so(so), .si(si), .rx_byte(p_rx), .frames(p_frames));

  // Clock and a low-frequency tick every fourth cycle.
  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    fs_cnt <= fs_cnt + 2'h1;
    fs_tick <= (fs_cnt == 2'h3);
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // The trailing delay lets the write edge land before anyone looks at the flags.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata, exp);
  endtask : rdc
  // Counts clock edges up to the next falling edge of the clock pin.
  task automatic fall_wait(output int cyc);
    logic prev;
    cyc = 1;
    prev = sck;
    @(posedge clk);
    while (!(prev === 1'b1 && sck === 1'b0) && cyc < 10000)
    begin
      prev = sck;
      @(posedge clk);
      cyc++;
    end
  endtask : fall_wait
  task automatic fstop;
    wr(8'h20, 8'h40);
    cmp(status, 8'h20);
    cmp(sck_out, 1'b1);
    p_clr <= 1'b1;
    @(posedge clk);
    p_clr <= 1'b0;
    rdc(8'h20, 8'h00);
    rdc(8'h22, 8'h00);
  endtask : fstop

  task automatic t_reset;
    rdc(8'h20, 8'h00);
    rdc(8'h21, 8'h20);
    rdc(8'h22, 8'h00);
    rdc(8'h33, 8'h00);
    cmp(sck_out, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_tx;
    logic [7:0] f0;
    f0 = p_frames;
    wr(8'h22, 8'hA5);
    cmp(status, 8'h00);
    wr(8'h22, 8'h3C);
    wr(8'h20, 8'h86);
    for (int i = 0; i < 500 && status.transfer_active_flag !== 1'b1; i++) @(posedge clk);
    #1;
    cmp(sck_out, 1'b0);
    cmp({status.clock_count_flag, status.tx_buffer_empty_flag}, 2'h3);
    for (int i = 0; i < 500 && p_frames === f0; i++) @(posedge clk);
    repeat (20) @(posedge clk);
    #1;
    cmp(p_rx, 8'hA5);
    cmp({status.transfer_active_flag, status.clock_count_flag, sck_out}, 3'h5);
    wr(8'h20, 8'h06);
    repeat (4) @(posedge clk);
    #1;
    cmp({status.transfer_active_flag, sck_out}, 2'h1);
    // Dropping the start bit mid-byte must still let that byte finish, then go idle.
    f0 = p_frames;
    wr(8'h22, 8'hC3);
    wr(8'h20, 8'h86);
    repeat (8) @(posedge clk);
    wr(8'h20, 8'h06);
    for (int i = 0; i < 500 && p_frames === f0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
    cmp({p_rx, status.transfer_active_flag, sck_out}, {8'hC3, 2'h1});
    $display("test transmit done");
  endtask : t_tx
  task automatic t_rx;
    p_lsb <= 1'b1;
    p_tx <= 8'h96;
    wr(8'h20, 8'h9D);
    for (int i = 0; i < 3000 && status.rx_buffer_full_flag !== 1'b1; i++) @(posedge clk);
    wr(8'h20, 8'h1D);
    cmp(so, 1'b1);
    rdc(8'h22, 8'h96);
    cmp(status.rx_buffer_full_flag, 1'b0);
    fstop;
    $display("test receive done");
  endtask : t_rx
  task automatic t_codes;
    int p;
    // Passes 7 and 8 run code 000 from the low-frequency tick, one through each option input.
    for (int c = 0; c < 9; c++)
    begin
      @(posedge clk);
      tb_sel <= (c == 7);
      slow <= (c == 8);
      wr(8'h22, 8'h5A);
      wr(8'h20, 8'hA0 | ((c > 6) ? 8'h00 : 8'(c)));
      fall_wait(p);
      fall_wait(p);
      cmp(16'(p), (c > 6) ? 16'(4 * FS_HALF * 2) : (16'h0001 << ((c == 0) ? 12 : 9 - c)));
      fstop;
    end
    @(posedge clk);
    tb_sel <= 1'b0;
    slow <= 1'b0;
    wr(8'h22, 8'h11);
    wr(8'h20, 8'hB6);
    repeat (40) @(posedge clk);
    #1;
    cmp({status.transfer_active_flag, sck_out}, 2'h1);
    fstop;
    $display("test clock codes done");
  endtask : t_codes
  task automatic pulses(input int k);
    for (int i = 0; i < k; i++)
    begin
      @(posedge clk);
      ext_sck <= 1'b0;
      repeat (4) @(posedge clk);
      ext_sck <= 1'b1;
      repeat (4) @(posedge clk);
    end
    #1;
  endtask : pulses
  task automatic t_ext;
    wr(8'h20, 8'h87);
    cmp(sck_oe, 1'b0);
    pulses(8);
    cmp(status.tx_underrun_flag, 1'b1);
    wr(8'h20, 8'h07);
    wr(8'h21, 8'hFF);
    cmp(status.tx_underrun_flag, 1'b1);
    wr(8'h21, 8'h00);
    cmp(status.tx_underrun_flag, 1'b0);
    wr(8'h20, 8'h97);
    pulses(16);
    cmp({status.rx_buffer_full_flag, status.rx_overrun_flag}, 2'h3);
    wr(8'h20, 8'h17);
    cmp(status.rx_overrun_flag, 1'b1);
    fstop;
    $display("test external clock done");
  endtask : t_ext

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  // Main sequence after a reset of twenty cycles.
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    p_clr <= 1'b0;
    t_reset;
    t_tx;
    t_rx;
    t_codes;
    t_ext;
    close_out;
  end
  // Watchdog, set well beyond the roughly eight thousand cycles the tests need.
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    $display("watchdog expired");
    close_out;
  end
endmodule : sync_serial_port_control_bench
